// File: inc/fsc_pkg.sv
// Purpose: Shared constants and types for the filter start control ends.
// Assumes: One sample clock at 50 MHz; active-low asynchronous reset.
// Notes:   Both the device end and the controller end compile against this.
package fsc_pkg;

    // Widths of the sample paths.
    localparam int DATA_W = 16;
    localparam int OUT_W  = 24;
    localparam int ACC_W  = 40;

    // Output formatter field positions within the accumulator word.
    localparam int UPPER_LSB_SEL  = 24;
    localparam int UPPER_LSB_NSEL = 16;
    localparam int LOWER_LSB_NORM = 16;
    localparam int BYP_LSB        = 16;

    // Reset value of the active-low start lines and chain output.
    localparam logic START_IDLE = 1'b1;

    // Controller pulse timing: high time before and low time of a start.
    localparam int PRE_HIGH_CYC = 2;
    localparam int PULSE_CYC    = 1;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    // Controller sequencing states.
    typedef enum logic [2:0] {
        FSC_IDLE,
        FSC_RESET,
        FSC_CONFIG,
        FSC_PREHIGH,
        FSC_PULSE,
        FSC_DONE
    } fsc_ctl_state_t;

endpackage

// File: inc/fsc_if.sv
// Purpose: Start link between the controlling party and the filter device.
// Assumes: Both ends run on the same sample clock.
// Notes:   Active-low start lines idle high.
`timescale 1ns/1ps
interface fsc_if (
    input wire logic mclk
);
    logic                         resetn_dev;
    logic                         async_start_in_n;
    logic                         sync_start_in_n;
    logic                         start_chain_out_n;
    logic                         sample_valid;
    logic [fsc_pkg::DATA_W-1:0]   sample_data;

    // Device end of the link.
    modport device (
        input  mclk,
        input  resetn_dev,
        input  async_start_in_n,
        input  sync_start_in_n,
        input  sample_valid,
        input  sample_data,
        output start_chain_out_n
    );

    // Controlling party's end of the link.
    modport host (
        input  mclk,
        input  start_chain_out_n,
        output resetn_dev,
        output async_start_in_n,
        output sync_start_in_n,
        output sample_valid,
        output sample_data
    );
endinterface

// File: design/fsc_device.sv
// Purpose: Start-up control of the decimating filter device.
// Assumes: Link clocked by mclk; async start may come from anywhere.
// Notes:   The datapath itself is reduced to gating and output formatting.
`timescale 1ns/1ps
module fsc_device (
    // Link
    fsc_if.device                      lnk,
    // Reset
    input  wire logic                  resetn,
    // Output formatting controls and accumulated result
    input  wire logic                  fir_bypass_select,
    input  wire logic                  upper_output_select,
    input  wire logic [fsc_pkg::ACC_W-1:0] acc_word,
    // User side
    output logic                       operating,
    output logic                       sample_take,
    output logic [fsc_pkg::DATA_W-1:0] sample_out,
    output logic [fsc_pkg::OUT_W-1:0]  data_out
);
    // Only the start logic is modelled in full. The accumulator word comes
    // in from outside and is formatted every cycle, whether or not the
    // device operates, because the datapath that would gate it is absent.

    // Combined reset of all start state.
    logic                       rst_n;
    // Synchronizer stages of the asynchronous start and their next values.
    logic                       async_s1;
    logic                       async_s2;
    logic                       async_s3;
    logic                       next_async_s1;
    logic                       next_async_s2;
    logic                       next_async_s3;
    // Last level of the synchronous start and its next value.
    logic                       sync_prev;
    logic                       next_sync_prev;
    // Decoded start edges, both active high.
    logic                       async_fall;
    logic                       sync_fall;
    // Registered start chain and its next value.
    logic                       start_chain_out_n_q;
    logic                       next_chain;
    // Next values of the user side outputs.
    logic                       next_operating;
    logic                       next_take;
    logic [fsc_pkg::DATA_W-1:0] next_sample;
    logic [fsc_pkg::OUT_W-1:0]  next_data_out;

    // A start is a high level seen at one edge and a low level at the next,
    // so a line that simply stays low can never start the device twice.
    function automatic logic start_edge(input logic prev_lvl,
                                        input logic now_lvl);
        return prev_lvl & ~now_lvl;
    endfunction

    // Picks the byte that goes to the top of the output word.
    function automatic logic [7:0] upper_byte(
        input logic [fsc_pkg::ACC_W-1:0] acc,
        input int                        lsb);
        return acc[lsb +: 8];
    endfunction

    // The outer reset and the host's device reset both clear the start
    // state. The host drives its reset from a flop on mclk, so only the
    // outer reset can arrive at an arbitrary time.
    // either reset clears
    assign rst_n = resetn & lnk.resetn_dev;

    // Two stages settle the pin; the third only remembers the last settled
    // level for the edge test, so a metastable value never reaches it.
    // The price is three cycles of lead before the chain pulse, and a low
    // pulse shorter than one clock period may be missed altogether.
    // synchronize async start
    always_comb begin
        next_async_s1 = lnk.async_start_in_n;
        next_async_s2 = async_s1;
        next_async_s3 = async_s2;
    end

    // Synchronizer registers; the first stage feeds only the second.
    always_ff @(posedge lnk.mclk or negedge rst_n) begin
        if (!rst_n) begin
            async_s1 <= fsc_pkg::START_IDLE;
            async_s2 <= fsc_pkg::START_IDLE;
            async_s3 <= fsc_pkg::START_IDLE;
        end else begin
            async_s1 <= next_async_s1;
            async_s2 <= next_async_s2;
            async_s3 <= next_async_s3;
        end
    end

    // The synchronous start is already aligned to mclk; one register keeps
    // its last level for the edge test and adds no delay to the start.
    always_comb begin
        next_sync_prev = lnk.sync_start_in_n;
    end

    // Last level of the synchronous start, idle high after reset.
    always_ff @(posedge lnk.mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev <= fsc_pkg::START_IDLE;
        end else begin
            sync_prev <= next_sync_prev;
        end
    end

    // Both edge detectors reset to the idle high level, so a line that is
    // held high through reset gives no false edge on release.
    // edge only detect
    always_comb begin
        async_fall = start_edge(async_s3, async_s2);
        sync_fall  = start_edge(sync_prev, lnk.sync_start_in_n);
    end

    // The chain is low for one cycle and registered, so a downstream device
    // sees its falling edge at the same edge at which this device enters
    // operating mode; both then start together. A synchronous start does
    // not drive the chain, since the downstream devices share that pulse.
    // aligned to downstream
    always_comb begin
        next_chain = ~async_fall;
    end

    // Start chain register, idle high in reset.
    // chain from synchronized
    always_ff @(posedge lnk.mclk or negedge rst_n) begin
        if (!rst_n) begin
            start_chain_out_n_q <= fsc_pkg::START_IDLE;
        end else begin
            start_chain_out_n_q <= next_chain;
        end
    end

    // Operating mode is entered on a synchronous start edge directly, or on
    // the edge after the chain pulse for an asynchronous start, and is left
    // only through reset. A further start while operating changes nothing,
    // which keeps a stray pulse from disturbing a running filter.
    // sync start direct
    always_comb begin
        next_operating = operating | sync_fall | ~start_chain_out_n_q;
    end

    // Mode register; any reset drops it, so each reset needs a new start.
    // reset clears mode
    always_ff @(posedge lnk.mclk or negedge rst_n) begin
        if (!rst_n) begin
            operating <= 1'b0;
        end else begin
            operating <= next_operating;
        end
    end

    // Samples offered before operating mode are dropped without a trace,
    // and the held sample keeps the last value that was accepted. Valid and
    // data come from logic on mclk, so they need no synchronizer.
    // ignore until operating
    always_comb begin
        next_take   = operating & lnk.sample_valid;
        next_sample = sample_out;
        if (next_take) begin
            next_sample = lnk.sample_data;
        end
    end

    // Sample registers.
    always_ff @(posedge lnk.mclk or negedge rst_n) begin
        if (!rst_n) begin
            sample_take <= 1'b0;
            sample_out  <= '0;
        end else begin
            sample_take <= next_take;
            sample_out  <= next_sample;
        end
    end

    // Output formatting. The lower sixteen bits come from one fixed field
    // and the upper byte depends on the select pin, unless the bypass is
    // set: the word is then one contiguous field and the pin is ignored.
    // The word stays fractional two's complement in every mode.
    // output formatting
    always_comb begin
        next_data_out = {
            upper_byte(acc_word, fsc_pkg::UPPER_LSB_NSEL),
            acc_word[fsc_pkg::LOWER_LSB_NORM +: fsc_pkg::DATA_W]};
        if (fir_bypass_select) begin
            next_data_out = acc_word[fsc_pkg::BYP_LSB +: fsc_pkg::OUT_W];
        end else if (upper_output_select) begin
            next_data_out = {
                upper_byte(acc_word, fsc_pkg::UPPER_LSB_SEL),
                acc_word[fsc_pkg::LOWER_LSB_NORM +: fsc_pkg::DATA_W]};
        end
    end

    // Output word register. The word is not gated by operating mode, so a
    // user must qualify it with the mode flag.
    always_ff @(posedge lnk.mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= '0;
        end else begin
            data_out <= next_data_out;
        end
    end

    // The chain leaves straight from its flop.
    assign lnk.start_chain_out_n = start_chain_out_n_q;
endmodule

// File: design/fsc_host.sv
// Purpose: Controlling party that resets, configures and starts the device.
// Assumes: Same clock as the device; configuration done by a done strobe.
// Notes:   Drives exactly one of the two start lines per go request.
`timescale 1ns/1ps
module fsc_host (
    // Link
    fsc_if.host                        lnk,
    // Reset; the clock comes in on the link
    input  wire logic                  resetn,
    // User commands
    input  wire logic                  go,
    input  wire logic                  use_async,
    input  wire logic                  config_done,
    // User samples
    input  wire logic                  user_valid,
    input  wire logic [fsc_pkg::DATA_W-1:0] user_data,
    // Status
    output logic                       in_config,
    output logic                       started
);
    fsc_pkg::fsc_ctl_state_t state;
    fsc_pkg::fsc_ctl_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic       mode_async;
    logic       next_mode_async;
    logic       next_dev_rst_n;
    logic       next_async_n;
    logic       next_sync_n;
    logic       next_in_config;
    logic       next_started;
    logic       dev_rst_n;
    logic       async_n;
    logic       sync_n;

    always_comb begin
        next_state      = state;
        next_cnt        = cnt;
        next_mode_async = mode_async;
        next_dev_rst_n  = 1'b1;
        next_async_n    = 1'b1;
        next_sync_n     = 1'b1;
        next_in_config  = 1'b0;
        next_started    = started;
        case (state)
            fsc_pkg::FSC_IDLE: begin
                if (go) begin
                    next_mode_async = use_async;
                    next_started    = 1'b0;
                    next_dev_rst_n  = 1'b0;
                    next_state      = fsc_pkg::FSC_RESET;
                end
            end
            fsc_pkg::FSC_RESET: begin
                next_in_config = 1'b1;
                next_state     = fsc_pkg::FSC_CONFIG;
            end
            fsc_pkg::FSC_CONFIG: begin
                next_in_config = ~config_done;
                if (config_done) begin
                    next_cnt   = 4'(fsc_pkg::PRE_HIGH_CYC);
                    next_state = fsc_pkg::FSC_PREHIGH;
                end
            end
            fsc_pkg::FSC_PREHIGH: begin
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1) begin
                    next_cnt     = 4'(fsc_pkg::PULSE_CYC);
                    next_async_n = ~mode_async;
                    next_sync_n  = mode_async;
                    next_state   = fsc_pkg::FSC_PULSE;
                end
            end
            fsc_pkg::FSC_PULSE: begin
                next_cnt = cnt - 4'h1;
                if (cnt != 4'h1) begin
                    next_async_n = async_n;
                    next_sync_n  = sync_n;
                end else begin
                    next_started = 1'b1;
                    next_cnt     = fsc_pkg::CNT_ZERO;
                    next_state   = fsc_pkg::FSC_DONE;
                end
            end
            fsc_pkg::FSC_DONE: begin
                next_state = fsc_pkg::FSC_IDLE;
            end
            default: begin
                next_state = fsc_pkg::FSC_IDLE;
            end
        endcase
    end

    // Registers for sequencing and pin drive.
    always_ff @(posedge lnk.mclk or negedge resetn) begin
        if (!resetn) begin
            state      <= fsc_pkg::FSC_IDLE;
            cnt        <= fsc_pkg::CNT_ZERO;
            mode_async <= 1'b0;
            dev_rst_n  <= 1'b0;
            async_n    <= fsc_pkg::START_IDLE;
            sync_n     <= fsc_pkg::START_IDLE;
            in_config  <= 1'b0;
            started    <= 1'b0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            mode_async <= next_mode_async;
            dev_rst_n  <= next_dev_rst_n;
            async_n    <= next_async_n;
            sync_n     <= next_sync_n;
            in_config  <= next_in_config;
            started    <= next_started;
        end
    end

    // Samples pass straight through; the device gates them until it is operating.
    assign lnk.resetn_dev       = dev_rst_n;
    assign lnk.async_start_in_n = async_n;
    assign lnk.sync_start_in_n  = sync_n;
    assign lnk.sample_valid     = user_valid;
    assign lnk.sample_data      = user_data;
endmodule

// File: bench/fsc_assertions.sv
// Purpose: Concurrent checks on the start link between host and device.
// Assumes: One clock domain; resetn is the bench reset of both ends.
// Notes:   Sees only link signals, so device internals are judged by the tb.
`timescale 1ns/1ps
module fsc_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Start link
    input wire logic resetn_dev,
    input wire logic async_start_in_n,
    input wire logic sync_start_in_n,
    input wire logic start_chain_out_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    logic armed;
    logic next_armed;

    // A device reset arms one start; the start then disarms it again.
    always_comb begin
        next_armed = armed;
        if (!resetn_dev)
            next_armed = 1'b1;
        else if (!async_start_in_n || !sync_start_in_n)
            next_armed = 1'b0;
    end

    // Registered arm flag, cleared by the bench reset.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn)
            armed <= 1'b0;
        else
            armed <= next_armed;
    end

    order_reset_a: assert property (($fell(async_start_in_n) ||
        $fell(sync_start_in_n)) |-> armed) else $error("start before reset");
    async_sync_a: assert property ($fell(async_start_in_n)
        |-> sync_start_in_n) else $error("sync start low in async use");
    sync_async_a: assert property ($fell(sync_start_in_n)
        |-> async_start_in_n) else $error("async start low in sync use");
    start_prehigh_a: assert property (($fell(async_start_in_n) ||
        $fell(sync_start_in_n)) |-> $past(async_start_in_n, 2) &&
        $past(sync_start_in_n, 2)) else $error("start not high before");
    start_pulse_a: assert property (($fell(async_start_in_n) ||
        $fell(sync_start_in_n)) |=> async_start_in_n && sync_start_in_n)
        else $error("start pulse longer than one cycle");
    chain_follows_a: assert property ($fell(async_start_in_n) &&
        resetn_dev |-> ##[2:6] !start_chain_out_n)
        else $error("no chain pulse after async start");
    chain_single_a: assert property ($fell(start_chain_out_n)
        |=> start_chain_out_n) else $error("chain pulse too long");
    chain_reset_a: assert property (!resetn_dev
        |-> start_chain_out_n) else $error("chain low in device reset");

    cover property ($fell(start_chain_out_n));
    cover property ($fell(sync_start_in_n));
    cover property ($rose(resetn_dev));
endmodule

// File: bench/filter_start_control_tb.sv
// Purpose: Self-checking bench for the host and device ends of the link.
// Assumes: Inputs change 1 ns after the rising edge of mclk.
// Notes:   Runs async and sync start, gating, formatting and reset.
`timescale 1ns/1ps
module filter_start_control_tb;
    logic                       mclk = 1'b0;
    logic                       resetn = 1'b0;
    logic                       go = 1'b0;
    logic                       use_async = 1'b0;
    logic                       config_done = 1'b0;
    logic                       user_valid = 1'b0;
    logic [fsc_pkg::DATA_W-1:0] user_data = 16'h0000;
    logic                       fir_bypass_select = 1'b0;
    logic                       upper_output_select = 1'b0;
    logic [fsc_pkg::ACC_W-1:0]  acc_word = 40'h12_3456_789a;
    logic                       in_config;
    logic                       started;
    logic                       operating;
    logic                       sample_take;
    logic [fsc_pkg::DATA_W-1:0] sample_out;
    logic [fsc_pkg::OUT_W-1:0]  data_out;
    logic                       operating_down;
    int                         num_errors = 0;
    int                         n_compared = 0;

    // Sample clock at 50 MHz.
    always #10 mclk = ~mclk;

    fsc_if lnk (.mclk(mclk));
    fsc_host i_fsc_host (.lnk(lnk), .resetn(resetn), .go(go),
        .use_async(use_async), .config_done(config_done),
        .user_valid(user_valid), .user_data(user_data),
        .in_config(in_config), .started(started));
    fsc_device i_fsc_device (.lnk(lnk), .resetn(resetn),
        .fir_bypass_select(fir_bypass_select),
        .upper_output_select(upper_output_select), .acc_word(acc_word),
        .operating(operating), .sample_take(sample_take),
        .sample_out(sample_out), .data_out(data_out));
    fsc_assertions i_fsc_assertions (.mclk(mclk), .resetn(resetn),
        .resetn_dev(lnk.resetn_dev), .async_start_in_n(lnk.async_start_in_n),
        .sync_start_in_n(lnk.sync_start_in_n),
        .start_chain_out_n(lnk.start_chain_out_n));

    // A second device that must start on the same edge as the first.
    fsc_if lnk_down (.mclk(mclk));
    assign lnk_down.resetn_dev       = lnk.resetn_dev;
    assign lnk_down.async_start_in_n = fsc_pkg::START_IDLE;
    assign lnk_down.sync_start_in_n  = use_async ?
        lnk.start_chain_out_n : lnk.sync_start_in_n;
    assign lnk_down.sample_valid     = user_valid;
    assign lnk_down.sample_data      = user_data;
    fsc_device i_fsc_device_down (.lnk(lnk_down), .resetn(resetn),
        .fir_bypass_select(fir_bypass_select),
        .upper_output_select(upper_output_select), .acc_word(acc_word),
        .operating(operating_down), .sample_take(), .sample_out(),
        .data_out());

    // Compare and count; an unknown never passes.
    task automatic chk(input string name,
                       input logic [fsc_pkg::OUT_W-1:0] exp,
                       input logic [fsc_pkg::OUT_W-1:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Step n edges and land 1 ns after the last, where outputs are settled.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // One start from idle; samples offered during configuration must drop.
    task automatic run_start(input logic a);
        int   k;
        int   t_low;
        int   t_chn;
        logic ln;
        logic early;
        t_low = -1;
        early = 1'b0;
        t_chn = -1;
        go = 1'b1;
        use_async = a;
        tick(1);
        go = 1'b0;
        for (k = 0; k < 20 && in_config !== 1'b1; k++)
            tick(1);
        user_valid = 1'b1;
        user_data = a ? 16'h8001 : 16'h7ffe;
        for (k = 0; k < 4; k++) begin
            tick(1);
            chk("take_cfg", 24'h0, 24'(sample_take));
        end
        config_done = 1'b1;
        tick(1);
        config_done = 1'b0;
        // The lead from the sync start, or the chain for an async start, seen low to operating is one edge.
        for (k = 0; k < 30 && operating !== 1'b1; k++) begin
            ln = a ? lnk.async_start_in_n : lnk.sync_start_in_n;
            if (t_low < 0 && ln === 1'b0)
                t_low = k;
            if (t_chn < 0 && lnk.start_chain_out_n === 1'b0)
                t_chn = k;
            if (operating_down === 1'b1)
                early = 1'b1;
            tick(1);
        end
        chk("operating", 24'h1, 24'(operating));
        chk("lead", 24'h1, 24'(k - (a ? t_chn : t_low)));
        chk("op_down", 24'h1, 24'(operating_down));
        chk("down_early", 24'h0, 24'(early));
        tick(2);
        chk("take_run", 24'h1, 24'(sample_take));
        chk("sample", 24'(user_data), 24'(sample_out));
        chk("started", 24'h1, 24'(started));
        user_valid = 1'b0;
    endtask

    // In bypass the upper select must not change the output word.
    task automatic fmt_check();
        int k;
        fir_bypass_select = 1'b1;
        for (k = 0; k < 2; k++) begin
            upper_output_select = k[0];
            tick(3);
            chk("bypass_fmt", 24'h12_3456, data_out);
        end
        fir_bypass_select = 1'b0;
        upper_output_select = 1'b1;
        tick(3);
        chk("upper_fmt", 24'h34_3456, data_out);
        upper_output_select = 1'b0;
        tick(3);
        chk("lower_fmt", 24'h56_3456, data_out);
    endtask

    // Reset mid-run; without a new start, samples stay ignored.
    task automatic reset_check();
        resetn = 1'b0;
        tick(1);
        chk("op_reset", 24'h0, 24'(operating));
        resetn = 1'b1;
        user_valid = 1'b1;
        tick(20);
        chk("op_idle", 24'h0, 24'(operating));
        chk("take_idle", 24'h0, 24'(sample_take));
        user_valid = 1'b0;
    endtask

    // Single place where the run ends.
    task automatic test_done();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence: reset, async start, format, reset, sync start.
    initial begin
        tick(8);
        resetn = 1'b1;
        run_start(1'b1);
        fmt_check();
        reset_check();
        run_start(1'b0);
        test_done();
    end

    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        test_done();
    end
endmodule
